/* File: core/rbm_boot_select.sv */
// Purpose: catches the mode pins at reset, picks memory mode and boot method,
//   holds execution until boot completes, and runs the shared flag pin after reset
// Assumes: rst is the reset pin already brought onto clk_sys, active high;
//   mode pins and the shared flag pin pass two flip-flops before use
// Notes: the mode level is caught on every clock while reset is high, so the
//   value that stands at the release is the one kept
//
// Operation
// R1: memory mode caught at reset, then kept
// R2: CBA=000: byte load 32 words, full memory
// R3: CBA=010: no boot, fetch from address 0
// R4: pin D ignored when pin C low
// R5: CBA=100: host mode, byte load 32 words
// R6: CBA=101: host mode, wait host write 0
// R7: pin D low drives ack, high open-drain
// R8: mode C pin becomes flag two afterwards
// R9: outside driver releases mode pin at reset end
// R10: flag direction chosen by software before power-down
// R11: host mode drives only lowest address bit
// R12: wired-OR ack only in open-drain style
// R13: other pin patterns flagged as unsupported
`timescale 1ns/1ns
`default_nettype none
module rbm_boot_select (
	// clock, reset and enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	// mode pins: d, b, a dedicated; c shared with flag two
	input wire logic mode_d_pin,
	input wire logic mode_b_pin,
	input wire logic mode_a_pin,
	input wire logic flag_pin_two_in,
	output logic flag_pin_two_out,
	output logic flag_pin_two_oe_n,
	// byte-port dma word arrival during boot
	output logic byte_port_dma_start,
	input wire logic byte_port_dma_word,
	// host-port dma program memory write
	input wire logic host_port_dma_pm_wr,
	input wire logic [13:0] host_port_dma_addr,
	// host access acknowledge from the port logic, active low
	input wire logic host_access_ack_n_int,
	output logic host_access_ack_n_out,
	output logic host_access_ack_n_oe_n,
	// execution control
	output logic core_run,
	output logic [13:0] core_start_addr,
	output logic host_mem_mode,
	output logic addr_drive_low_only,
	output logic mode_unsupported,
	// register port
	input wire logic [rbm_pkg::RBM_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	// synchronised pins
	logic [3:0] pins_sync; // {d, c, b, a}
	logic [3:0] mode_ff; // mode pins caught during reset
	rbm_pkg::rbm_boot_e boot_ff; // decoded boot method
	rbm_pkg::rbm_boot_e nxt_boot; // decode of the caught pins
	logic host_mode_ff; // host memory mode kept after reset
	logic ack_od_ff; // acknowledge pin open-drain style
	logic run_ff; // execution released
	logic [5:0] word_cnt_ff; // boot words received
	logic start_ff; // byte load start pulse
	logic started_ff; // byte load start already issued
	logic flag_dir_ff; // flag two direction, 1 = output
	logic flag_out_ff; // flag two output level
	logic flag_oe_n_ff; // registered pin enable
	logic ack_out_ff; // registered ack level
	logic ack_oe_n_ff; // registered ack enable
	logic [7:0] rdata_ff; // read data
	logic [13:0] start_addr_ff; // first fetch address
	logic bad_ff; // unsupported pattern seen

	rbm_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst(1'b0),
		.clk_en(clk_en),
		.din({mode_d_pin, flag_pin_two_in, mode_b_pin, mode_a_pin}),
		.dout(pins_sync)
	);

	// decode of the caught pattern
	wire pin_d = mode_ff[3];
	wire pin_c = mode_ff[2];
	wire pin_b = mode_ff[1];
	wire pin_a = mode_ff[0];
	always_comb begin
		// pin d plays no part here, only in the ack style
		nxt_boot = rbm_pkg::RBM_BOOT_BAD; // R13
		if (!pin_c && !pin_b && !pin_a) begin
			nxt_boot = rbm_pkg::RBM_BOOT_BYTE; // R2 R4
		end else if (!pin_c && pin_b && !pin_a) begin
			nxt_boot = rbm_pkg::RBM_BOOT_NONE; // R3 R4
		end else if (pin_c && !pin_b && !pin_a) begin
			nxt_boot = rbm_pkg::RBM_BOOT_BYTE; // R5
		end else if (pin_c && !pin_b && pin_a) begin
			nxt_boot = rbm_pkg::RBM_BOOT_HOST; // R6
		end
	end

	// boot events
	wire boot_is_byte = (boot_ff == rbm_pkg::RBM_BOOT_BYTE);
	wire boot_is_host = (boot_ff == rbm_pkg::RBM_BOOT_HOST);
	wire last_word = byte_port_dma_word && (word_cnt_ff == rbm_pkg::RBM_BOOT_WORDS_6 - 6'h01);
	wire host_go = host_port_dma_pm_wr && (host_port_dma_addr == rbm_pkg::RBM_HOST_GO_ADDR);
	wire nxt_run = boot_is_byte ? last_word : (boot_is_host ? host_go : 1'b0);

	// register decode
	wire sel_status = (reg_addr == rbm_pkg::RBM_REG_STATUS);
	wire sel_flag = (reg_addr == rbm_pkg::RBM_REG_FLAG);
	wire sel_cnt = (reg_addr == rbm_pkg::RBM_REG_BOOTCNT);
	wire flag_wr = reg_wr && sel_flag && !rst;
	wire [7:0] status_word = {2'h0, boot_ff, ack_od_ff, bad_ff, run_ff, host_mode_ff};
	wire [7:0] flag_word = {5'h00, pins_sync[2], flag_dir_ff, flag_out_ff};
	wire [7:0] nxt_rdata = sel_status ? status_word : (sel_flag ? flag_word : (sel_cnt ? {2'h0, word_cnt_ff} : 8'h00));

	// acknowledge pin style: driven both ways or pull low only
	wire ack_drive = host_mode_ff && !rst;
	wire nxt_ack_oe_n = !ack_drive || (ack_od_ff && host_access_ack_n_int); // R7
	wire nxt_ack_out = ack_od_ff ? 1'b0 : host_access_ack_n_int; // R7

	// mode capture while reset holds
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			if (clk_en) begin
				mode_ff <= pins_sync; // R1
			end
		end
	end

	// decoded configuration, fixed from release onward
	always_ff @(posedge clk_sys) begin
		if (clk_en) begin
			if (rst) begin
				boot_ff <= nxt_boot;
				host_mode_ff <= pin_c; // R1
				ack_od_ff <= pin_d; // R7
				bad_ff <= (nxt_boot == rbm_pkg::RBM_BOOT_BAD); // R13
				start_addr_ff <= rbm_pkg::RBM_START_ADDR; // R3
			end
		end
	end

	// execution hold and boot word count
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			run_ff <= 1'b0;
			word_cnt_ff <= 6'h00;
		end else if (clk_en) begin
			if (boot_ff == rbm_pkg::RBM_BOOT_NONE) begin
				run_ff <= 1'b1; // R3
			end else if (nxt_run) begin
				run_ff <= 1'b1; // R2 R5 R6
			end
			if (boot_is_byte && byte_port_dma_word && !run_ff) begin
				word_cnt_ff <= word_cnt_ff + 6'h01; // R2 R5
			end
		end
	end

	// one start pulse for the byte load after release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_ff <= 1'b0;
			started_ff <= 1'b0;
		end else if (clk_en) begin
			start_ff <= boot_is_byte && !started_ff;
			started_ff <= started_ff || boot_is_byte;
		end
	end

	// shared flag pin: released during reset, software owned after
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_dir_ff <= rbm_pkg::RBM_FLAG_DIR_RST;
			flag_out_ff <= rbm_pkg::RBM_FLAG_OUT_RST;
			flag_oe_n_ff <= 1'b1;
		end else if (clk_en) begin
			if (flag_wr) begin
				flag_out_ff <= reg_wdata[rbm_pkg::RBM_FL_OUT]; // R8 R10
				flag_dir_ff <= reg_wdata[rbm_pkg::RBM_FL_DIR]; // R8 R10
			end
			flag_oe_n_ff <= !flag_dir_ff; // R8 R9
		end
	end

	// acknowledge pin and read data registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_out_ff <= 1'b1;
			ack_oe_n_ff <= 1'b1;
			rdata_ff <= 8'h00;
		end else if (clk_en) begin
			ack_out_ff <= nxt_ack_out;
			ack_oe_n_ff <= nxt_ack_oe_n;
			rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
		end
	end

	// outputs
	assign flag_pin_two_out = flag_out_ff;
	assign flag_pin_two_oe_n = flag_oe_n_ff;
	assign byte_port_dma_start = start_ff;
	assign host_access_ack_n_out = ack_out_ff;
	assign host_access_ack_n_oe_n = ack_oe_n_ff;
	assign core_run = run_ff;
	assign core_start_addr = start_addr_ff;
	assign host_mem_mode = host_mode_ff;
	assign addr_drive_low_only = host_mode_ff; // R11
	assign mode_unsupported = bad_ff;
	assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

/* File: core/rbm_pkg.sv */
// Purpose: shared constants for the reset-time boot and memory-mode selector
// Assumes: 100 MHz system clock, mode pins sampled while the reset pin is high
// Notes: the register port offsets are word indices on a plain strobe port
package rbm_pkg;
	// boot method decoded from the mode pins
	typedef enum logic [1:0] {
		RBM_BOOT_BYTE,
		RBM_BOOT_NONE,
		RBM_BOOT_HOST,
		RBM_BOOT_BAD
	} rbm_boot_e;
	// register port width and offsets
	localparam int unsigned RBM_ADDR_W = 4;
	localparam logic [3:0] RBM_REG_STATUS = 4'h0;
	localparam logic [3:0] RBM_REG_FLAG = 4'h1;
	localparam logic [3:0] RBM_REG_BOOTCNT = 4'h2;
	// status field positions
	localparam int unsigned RBM_ST_HOSTMODE = 0;
	localparam int unsigned RBM_ST_RUN = 1;
	localparam int unsigned RBM_ST_BAD = 2;
	localparam int unsigned RBM_ST_ACKOD = 3;
	localparam int unsigned RBM_ST_BOOT_LO = 4;
	// flag register field positions
	localparam int unsigned RBM_FL_OUT = 0;
	localparam int unsigned RBM_FL_DIR = 1;
	localparam int unsigned RBM_FL_IN = 2;
	// boot load length in program words
	localparam int unsigned RBM_BOOT_WORDS = 32;
	localparam logic [5:0] RBM_BOOT_WORDS_6 = 6'h20;
	// first fetch address and host release address
	localparam logic [13:0] RBM_START_ADDR = 14'h0000;
	localparam logic [13:0] RBM_HOST_GO_ADDR = 14'h0000;
	// reset values
	localparam logic RBM_FLAG_DIR_RST = 1'h0;
	localparam logic RBM_FLAG_OUT_RST = 1'h0;
	// synchroniser depth
	localparam int unsigned RBM_SYNC_STAGES = 2;
endpackage

/* File: core/rbm_sync.sv */
// Purpose: two-stage synchroniser for pins arriving from outside the clock domain
// Assumes: the width is a parameter; the clock enable freezes the stages
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module rbm_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	// pins in and synchronised out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff; // first stage, read only by second
	logic [WIDTH-1:0] hold_ff; // second stage

	// two flip-flops per bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_ff <= '0;
			hold_ff <= '0;
		end else if (clk_en) begin
			meta_ff <= din;
			hold_ff <= meta_ff;
		end
	end

	assign dout = hold_ff;
endmodule
`default_nettype wire

/* File: tb/rbm_boot_select_properties.sv */
// Purpose: port checker for the boot and memory-mode selector
// Assumes: one clock, synchronous reset active high
// Notes: bound onto every selector instance
`timescale 1ns/1ns
`default_nettype none
module rbm_boot_select_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// watched ports
	input wire logic byte_port_dma_start,
	input wire logic byte_port_dma_word,
	input wire logic host_port_dma_pm_wr,
	input wire logic host_access_ack_n_oe_n,
	input wire logic flag_pin_two_oe_n,
	input wire logic core_run,
	input wire logic host_mem_mode,
	input wire logic addr_drive_low_only,
	input wire logic mode_unsupported,
	input wire logic [rbm_pkg::RBM_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	mode_kept_a: assert property ($stable(host_mem_mode)) else $error("memory mode moved");
	run_held_a: assert property (core_run |=> core_run) else $error("run dropped");
	start_pulse_a: assert property (byte_port_dma_start |=> !byte_port_dma_start && !core_run)
		else $error("start pulse wrong");
	addr_low_a: assert property (addr_drive_low_only == host_mem_mode) else $error("address drive wrong");
	ack_idle_a: assert property (!host_mem_mode |-> host_access_ack_n_oe_n) else $error("ack driven");
	bad_halt_a: assert property (mode_unsupported |-> !core_run && !byte_port_dma_start) else $error("bad ran");
	run_cause_a: assert property ($rose(core_run) |-> $past(byte_port_dma_word) || $past(host_port_dma_pm_wr)
		|| $past(rst, 2) || $past(rst, 3)) else $error("run without cause");
	flag_dir_a: assert property (reg_wr && reg_addr == rbm_pkg::RBM_REG_FLAG |-> ##2
		flag_pin_two_oe_n == !$past(reg_wdata[1], 2)) else $error("flag direction wrong");
endmodule
bind rbm_boot_select rbm_boot_select_chk u_chk (.clk_sys(clk_sys), .rst(rst),
	.byte_port_dma_start(byte_port_dma_start), .byte_port_dma_word(byte_port_dma_word),
	.host_port_dma_pm_wr(host_port_dma_pm_wr), .host_access_ack_n_oe_n(host_access_ack_n_oe_n),
	.flag_pin_two_oe_n(flag_pin_two_oe_n), .core_run(core_run), .host_mem_mode(host_mem_mode),
	.addr_drive_low_only(addr_drive_low_only), .mode_unsupported(mode_unsupported),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));
`default_nettype wire

/* File: tb/rbm_far_end.sv */
// Purpose: byte memory model that answers a boot start with word pulses
// Assumes: pace sets idle cycles between words
// Notes: delivers exactly one boot block per start
`timescale 1ns/1ns
`default_nettype none
module rbm_far_end (
	// clock and pacing
	input wire logic clk_sys,
	input wire logic [1:0] pace,
	// boot handshake
	input wire logic byte_port_dma_start,
	output logic byte_port_dma_word = 1'b0
);
	logic [5:0] left_ff = 6'h00; // words still owed
	logic [1:0] gap_ff = 2'h0; // idle cycles since last word
	// one word every pace+1 cycles until the block is done
	always @(posedge clk_sys) begin
		byte_port_dma_word <= 1'b0;
		gap_ff <= gap_ff + 2'h1;
		if (byte_port_dma_start) begin
			left_ff <= 6'h20;
		end else if (left_ff != 6'h00 && gap_ff >= pace) begin
			byte_port_dma_word <= 1'b1;
			left_ff <= left_ff - 6'h01;
			gap_ff <= 2'h0;
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: boot mode, ack style and flag pin scenarios
// Assumes: mode pins applied while reset is held
// Notes: shared pin resolved from the device enable
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] mode = 4'h0; // pins d c b a
	logic pin_ext = 1'b0; // outside drive of the shared pin
	logic pm_wr = 1'b0;
	logic [13:0] pm_addr = 14'h3fff;
	logic ack_int = 1'b1;
	logic [1:0] pace = 2'h2;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	wire logic f_out, f_oe_n, d_start, d_word, a_out, a_oe_n, core_run, host_mem, bad, low_only;
	wire logic [7:0] reg_rdata;
	wire logic [13:0] start_addr;
	wire logic f_pin = f_oe_n ? pin_ext : f_out; // shared pin level
	int n_errors = 0;
	int checks = 0;
	always #5 clk_sys = ~clk_sys;
	rbm_boot_select u_rbm_boot_select (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
		.mode_d_pin(mode[3]), .mode_b_pin(mode[1]), .mode_a_pin(mode[0]), .flag_pin_two_in(f_pin),
		.flag_pin_two_out(f_out), .flag_pin_two_oe_n(f_oe_n), .byte_port_dma_start(d_start),
		.byte_port_dma_word(d_word), .host_port_dma_pm_wr(pm_wr), .host_port_dma_addr(pm_addr),
		.host_access_ack_n_int(ack_int), .host_access_ack_n_out(a_out), .host_access_ack_n_oe_n(a_oe_n),
		.core_run(core_run), .core_start_addr(start_addr), .host_mem_mode(host_mem), .addr_drive_low_only(low_only),
		.mode_unsupported(bad), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	rbm_far_end u_rbm_far_end (.clk_sys(clk_sys), .pace(pace), .byte_port_dma_start(d_start),
		.byte_port_dma_word(d_word));
	task automatic wrap_up;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] msk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys) reg_rd <= 1'b0;
		@(posedge clk_sys) chk(reg_rdata & msk, exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask
	task automatic host_wr(input logic [13:0] a);
		pm_wr <= 1'b1;
		pm_addr <= a;
		@(posedge clk_sys) pm_wr <= 1'b0;
		pm_addr <= 14'h3fff;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic ack(input logic [1:0] e0, input logic [1:0] e1);
		ack_int <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({a_oe_n, a_out}, e0);
		ack_int <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({a_oe_n, a_out}, e1);
	endtask
	// reset with mode pins set, then follow the boot to its end
	task automatic cfg(input logic [3:0] m, input logic early, input logic [7:0] st, input logic [7:0] msk);
		int n;
		rst <= 1'b1;
		mode <= m;
		pin_ext <= m[2];
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys) pin_ext <= ~m[2];
		repeat (40) @(posedge clk_sys);
		chk(core_run, early);
		if (m[2:0] == 3'b101) begin
			host_wr(14'h0005);
			chk(core_run, 1'b0);
			host_wr(14'h0000);
		end
		n = 0;
		while (core_run !== 1'b1 && n < 100) begin
			@(posedge clk_sys) n++;
		end
		chk(host_mem, m[2]);
		chk(low_only, m[2]);
		chk(bad, !(m[2:0] inside {3'b000, 3'b010, 3'b100, 3'b101}));
		rd(4'h0, st, msk);
	endtask
	initial begin
		#100000 n_errors++;
		wrap_up;
	end
	initial begin
		cfg(4'b1000, 1'b0, 8'h02, 8'hf7);
		pace <= 2'h1;
		cfg(4'b0000, 1'b0, 8'h02, 8'hf7);
		rd(4'h2, 8'h20, 8'hff);
		cfg(4'b1010, 1'b1, 8'h12, 8'hf7);
		chk(start_addr, 14'h0000);
		cfg(4'b0100, 1'b0, 8'h03, 8'hff);
		ack(2'b00, 2'b01);
		cfg(4'b1101, 1'b0, 8'h2b, 8'hff);
		ack(2'b00, 2'b10);
		wr(4'h1, 8'h03);
		repeat (4) @(posedge clk_sys);
		chk({f_oe_n, f_out}, 2'b01);
		rd(4'h1, 8'h07, 8'hff);
		wr(4'h1, 8'h00);
		repeat (4) @(posedge clk_sys);
		rd(4'h1, 8'h00, 8'hff);
		chk(host_mem, 1'b1);
		rd(4'h7, 8'h00, 8'hff);
		cfg(4'b0110, 1'b0, 8'h34, 8'hf6);
		wrap_up;
	end
endmodule
`default_nettype wire
